/* hardware_limit_timer.sv */
/*
  Hardware limit timer: 8-bit count/period pair with prescaler, postscaler,
  match flag and edge-triggered external clear, behind a Wishbone slave.
  Assumes all inputs synchronous to clk_i and a single-cycle classic master.
*/
// Our own choices: register access over Wishbone and the placing of the registers.
// Behaviour
// - 8-bit counter and period, software read/write
// - Counts instruction clock, quarter of system clock
// - Prescaler 1, 4 or 16 by select
// - Match at a timer tick reloads count to zero
// - Unscaled match drives limit output to generator
// - Postscaler 1:1 to 1:16 sets match flag
// - Interrupt forwarded only while enable set
// - Reset clears count, period becomes all ones
// - Count or control0 write clears both scalers
// - Control0 write leaves count unchanged
// - Three-bit select picks one of six sources
// - Source codes map to peripheral outputs or zero
// - External event clears count at next tick
// - Rising and falling edges individually enabled
// - Control1 bit1 falling, bit0 rising enable
// - External clear gives no match, no postscale
// - Sleep stops timer and holds count
// - Control0 layout: postscale, on, prescale, bit7 zero
`timescale 1ns/10ps
`include "hlt_defs.svh"

module hardware_limit_timer #(
  parameter int COUNT_W = 8
) (
  input wire logic clk_i, // 50 MHz system clock
  input wire logic rst_i, // Any device reset, synchronous
  input wire logic [`ADR_W-1:0] wb_adr_i, // Byte address
  input wire logic [`DAT_W-1:0] wb_dat_i, // Write data
  output logic [`DAT_W-1:0] wb_dat_o, // Read data
  input wire logic wb_we_i, // Write strobe qualifier
  input wire logic [3:0] wb_sel_i, // Byte enables
  input wire logic wb_cyc_i, // Bus cycle
  input wire logic wb_stb_i, // Strobe
  output logic wb_ack_o, // Acknowledge
  input wire logic sleep_i, // Processor asleep
  input wire hlt_pkg::reset_src_t reset_src_i, // Peripheral reset sources
  output logic limit_output_o, // Match pulse to output generator
  output logic limit_irq_o // Gated match interrupt
);

  if (COUNT_W != `BYTE_W)
  begin : g_bad_count
    $error("hardware_limit_timer supports an 8-bit count only");
  end

  hlt_pkg::state_t st_reg;
  hlt_pkg::state_t st_next;

  logic bus_req;
  logic wr;
  logic wr_count;
  logic wr_ctrl0;
  logic scaler_clear;
  logic inst_tick;
  logic running;
  logic pre_step;
  logic pre_tick;
  logic [`PRE_W-1:0] pre_limit;
  logic sel_src;
  logic ext_event;
  logic ext_clear;
  logic match;
  logic match_step;
  logic post_tick;

  // Instruction clock enable
  pulse_divider #(.WIDTH(`INST_DIV_W)) u_inst_div (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .clear_i(1'b0),
    .step_i(1'b1),
    .limit_i(`INST_DIV_LIMIT),
    .pulse_o(inst_tick)
  );

  pulse_divider #(.WIDTH(`PRE_W)) u_prescaler (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .clear_i(scaler_clear),
    .step_i(pre_step),
    .limit_i(pre_limit),
    .pulse_o(pre_tick)
  );

  pulse_divider #(.WIDTH(`POST_W)) u_postscaler (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .clear_i(scaler_clear),
    .step_i(match_step),
    .limit_i(st_reg.limit_control_0.postscale_select),
    .pulse_o(post_tick)
  );

  always_comb
  begin
    st_next = st_reg;

    bus_req = wb_cyc_i & wb_stb_i & ~st_reg.ack;
    wr = bus_req & wb_we_i & wb_sel_i[0];
    wr_count = wr & (wb_adr_i == `OFS_COUNT);
    wr_ctrl0 = wr & (wb_adr_i == `OFS_CTRL0);
    scaler_clear = wr_count | wr_ctrl0;

    // Off or asleep freezes everything downstream of the instruction clock
    running = st_reg.limit_control_0.timer_on & ~sleep_i;
    pre_step = inst_tick & running;

    case (st_reg.limit_control_0.prescale_select)
      `PRE_SEL_1: pre_limit = `PRE_LIM_1;
      `PRE_SEL_4: pre_limit = `PRE_LIM_4;
      default: pre_limit = `PRE_LIM_16;
    endcase

    case (st_reg.limit_control_1.reset_source_select)
      `SRC_CCP: sel_src = reset_src_i.capture_compare_unit;
      `SRC_CMP1: sel_src = reset_src_i.comparator_one_output;
      `SRC_CMP2: sel_src = reset_src_i.comparator_two_output;
      `SRC_FAULT: sel_src = reset_src_i.generator_fault;
      `SRC_GEN0: sel_src = reset_src_i.generator_out0;
      `SRC_GEN1: sel_src = reset_src_i.generator_out1;
      default: sel_src = 1'b0;
    endcase

    st_next.src_prev = sel_src;
    ext_event = (st_reg.limit_control_1.rise_reset_enable & sel_src & ~st_reg.src_prev)
      | (st_reg.limit_control_1.fall_reset_enable & ~sel_src & st_reg.src_prev);

    // Event is held until the next timer tick consumes it
    ext_clear = pre_tick & (st_reg.reset_pending | ext_event);
    if (pre_tick)
      st_next.reset_pending = 1'b0;
    else if (ext_event)
      st_next.reset_pending = 1'b1;

    match = (st_reg.limit_count == st_reg.limit_period);
    match_step = pre_tick & match & ~ext_clear;
    st_next.limit_output = match_step;

    if (wr_count)
      st_next.limit_count = wb_dat_i[COUNT_W-1:0];
    else if (pre_tick)
    begin
      if (ext_clear | match)
        st_next.limit_count = `COUNT_RST;
      else
        st_next.limit_count = COUNT_W'(st_reg.limit_count + 1'b1);
    end

    if (wr & (wb_adr_i == `OFS_PERIOD))
      st_next.limit_period = wb_dat_i[COUNT_W-1:0];
    if (wr_ctrl0)
      st_next.limit_control_0 = hlt_pkg::ctrl0_t'(wb_dat_i[`CTRL0_W-1:0]);
    if (wr & (wb_adr_i == `OFS_CTRL1))
      st_next.limit_control_1 = hlt_pkg::ctrl1_t'(wb_dat_i[`CTRL1_W-1:0]);

    // Write one clears the flag; a same-cycle overflow wins
    if (wr & (wb_adr_i == `OFS_FLAG))
    begin
      st_next.limit_match_irq_enable = wb_dat_i[`IRQ_EN_BIT];
      if (wb_dat_i[`FLAG_BIT])
        st_next.limit_match_flag = 1'b0;
    end
    if (post_tick)
      st_next.limit_match_flag = 1'b1;
    st_next.irq = st_next.limit_match_flag & st_next.limit_match_irq_enable;

    st_next.ack = bus_req;
    if (bus_req)
    begin
      case (wb_adr_i)
        `OFS_COUNT: st_next.rdata = {{(`DAT_W-COUNT_W){1'b0}}, st_reg.limit_count};
        `OFS_PERIOD: st_next.rdata = {{(`DAT_W-COUNT_W){1'b0}}, st_reg.limit_period};
        `OFS_CTRL0: st_next.rdata = {{(`DAT_W-`CTRL0_W){1'b0}}, st_reg.limit_control_0};
        `OFS_CTRL1: st_next.rdata = {{(`DAT_W-`CTRL1_W){1'b0}}, st_reg.limit_control_1};
        `OFS_FLAG: st_next.rdata = {{(`DAT_W-`FLAG_W){1'b0}},
          st_reg.limit_match_irq_enable, st_reg.limit_match_flag};
        default: st_next.rdata = '0;
      endcase
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      st_reg <= '0;
      st_reg.limit_count <= `COUNT_RST;
      st_reg.limit_period <= `PERIOD_RST;
    end
    else
      st_reg <= st_next;
  end

  assign wb_dat_o = st_reg.rdata;
  assign wb_ack_o = st_reg.ack;
  assign limit_output_o = st_reg.limit_output;
  assign limit_irq_o = st_reg.irq;

endmodule // hardware_limit_timer

/* hlt_defs.svh */
/*
  Register offsets, field widths, reset values and divider limits for the
  hardware limit timer. Assumes inclusion by bare name from design files.
*/
`ifndef HLT_DEFS_SVH
`define HLT_DEFS_SVH

// Word-aligned byte offsets on the Wishbone bus
`define OFS_COUNT 8'h00
`define OFS_PERIOD 8'h04
`define OFS_CTRL0 8'h08
`define OFS_CTRL1 8'h0c
`define OFS_FLAG 8'h10

`define ADR_W 8
`define DAT_W 32
`define BYTE_W 8
`define CTRL0_W 7
`define CTRL1_W 5
`define FLAG_W 2
`define FLAG_BIT 0
`define IRQ_EN_BIT 1

`define PERIOD_RST 8'hff
`define COUNT_RST 8'h00

// Instruction clock is a quarter of the system clock
`define INST_DIV_LIMIT 2'h3
`define INST_DIV_W 2

`define PRE_W 4
`define PRE_LIM_1 4'h0
`define PRE_LIM_4 4'h3
`define PRE_LIM_16 4'hf
`define PRE_SEL_1 2'h0
`define PRE_SEL_4 2'h1

`define POST_W 4

`define SRC_CCP 3'h0
`define SRC_CMP1 3'h1
`define SRC_CMP2 3'h2
`define SRC_FAULT 3'h3
`define SRC_GEN0 3'h4
`define SRC_GEN1 3'h5

`endif

/* hlt_pkg.sv */
/*
  Types shared by the hardware limit timer: control register layouts,
  the reset source bundle and the module state record.
  Assumes hlt_defs.svh is reachable on the include path.
*/
`include "hlt_defs.svh"

package hlt_pkg;

  typedef struct packed {
    logic [3:0] postscale_select;
    logic timer_on;
    logic [1:0] prescale_select;
  } ctrl0_t;

  typedef struct packed {
    logic [2:0] reset_source_select;
    logic fall_reset_enable;
    logic rise_reset_enable;
  } ctrl1_t;

  typedef struct packed {
    logic capture_compare_unit;
    logic comparator_one_output;
    logic comparator_two_output;
    logic generator_fault;
    logic generator_out0;
    logic generator_out1;
  } reset_src_t;

  typedef struct packed {
    logic [7:0] limit_count;
    logic [7:0] limit_period;
    ctrl0_t limit_control_0;
    ctrl1_t limit_control_1;
    logic limit_match_flag;
    logic limit_match_irq_enable;
    logic src_prev;
    logic reset_pending;
    logic limit_output;
    logic irq;
    logic ack;
    logic [31:0] rdata;
  } state_t;

endpackage

/* pulse_divider.sv */
/*
  Modulo counter that emits a one-cycle pulse on the step that wraps it.
  Assumes a synchronous active-high reset; clear has priority over step.
*/
`timescale 1ns/10ps

module pulse_divider #(
  parameter int WIDTH = 4
) (
  input wire logic clk_i, // System clock
  input wire logic rst_i, // Synchronous reset
  input wire logic clear_i, // Restart count at zero
  input wire logic step_i, // Advance by one
  input wire logic [WIDTH-1:0] limit_i, // Wrap value, ratio is limit+1
  output logic pulse_o // High on the wrapping step
);

  if (WIDTH < 1)
  begin : g_bad_width
    $error("pulse_divider needs WIDTH of at least 1");
  end

  logic [WIDTH-1:0] cnt_reg;
  logic [WIDTH-1:0] cnt_next;
  logic wrap;

  always_comb
  begin
    wrap = (cnt_reg >= limit_i);
    cnt_next = cnt_reg;
    pulse_o = 1'b0;
    if (clear_i)
    begin
      cnt_next = '0;
    end
    else if (step_i)
    begin
      pulse_o = wrap;
      cnt_next = wrap ? '0 : WIDTH'(cnt_reg + 1'b1);
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      cnt_reg <= '0;
    else
      cnt_reg <= cnt_next;
  end

endmodule // pulse_divider

/* hlt_src_model.sv */
/* Far-side peripheral outputs that feed the timer's clear select.
   Assumes the bench changes which_i and lvl_i just after a clock edge. */
`timescale 1ns/10ps
module hlt_src_model (
  input wire logic [2:0] which_i, // Source to move
  input wire logic lvl_i, // Its level
  output hlt_pkg::reset_src_t src_o // Peripheral outputs
);
  // Codes 6 and 7 have nothing behind them
  assign src_o = (lvl_i && which_i < 3'h6) ? hlt_pkg::reset_src_t'(6'h20 >> which_i) : '0;
endmodule // hlt_src_model

/* hardware_limit_timer_asserts.sv */
/* Port checker for the hardware limit timer.
   Assumes the bind below onto the top module. */
`timescale 1ns/10ps
module hardware_limit_timer_asserts (
  input wire logic clk_i, // Clock
  input wire logic rst_i, // Reset
  input wire logic wb_cyc_i, // Cycle
  input wire logic wb_stb_i, // Strobe
  input wire logic wb_we_i, // Write
  input wire logic wb_ack_o, // Ack
  input wire logic [31:0] wb_dat_o, // Read data
  input wire logic sleep_i, // Asleep
  input wire logic limit_output_o, // Match
  input wire logic limit_irq_o // Irq
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_ack_follows: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("no ack");
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack too long");
  a_ack_cause: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack unasked");
  a_read_upper: assert property (wb_ack_o && !wb_we_i |-> wb_dat_o[31:8] == 24'h0)
    else $error("upper read bits");
  a_limit_gap: assert property (limit_output_o |=> !limit_output_o [*3])
    else $error("match too soon");
  a_sleep_hold: assert property ($past(sleep_i) |-> !limit_output_o)
    else $error("match asleep");
  a_irq_cause: assert property ($rose(limit_irq_o) |-> limit_output_o || $past(limit_output_o)
    || $past(limit_output_o, 2) || $past(wb_we_i) || $past(wb_we_i, 2)) else $error("irq uncaused");
  a_reset_quiet: assert property ($fell(rst_i) |-> !limit_output_o && !limit_irq_o)
    else $error("outputs after reset");
endmodule // hardware_limit_timer_asserts
bind hardware_limit_timer hardware_limit_timer_asserts u_chk (.clk_i(clk_i), .rst_i(rst_i),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_ack_o(wb_ack_o),
  .wb_dat_o(wb_dat_o), .sleep_i(sleep_i), .limit_output_o(limit_output_o),
  .limit_irq_o(limit_irq_o));

/* hardware_limit_timer_tb.sv */
/* Bench for the hardware limit timer.
   Assumes the source model and the checker are compiled first. */
`timescale 1ns/10ps
module hardware_limit_timer_tb;
  logic clk_i = 0, rst_i = 1, wb_we_i = 0, wb_cyc_i = 0, wb_stb_i = 0, sleep_i = 0, lvl = 0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd;
  logic [2:0] which = 3'h0;
  logic wb_ack_o, limit_output_o, limit_irq_o;
  hlt_pkg::reset_src_t src;
  int num_errors = 0, checks = 0, n;
  always #10 clk_i = ~clk_i;
  hlt_src_model srcm (.which_i(which), .lvl_i(lvl), .src_o(src));
  hardware_limit_timer uut (.clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(wb_adr_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_we_i(wb_we_i), .wb_sel_i(4'hf),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .sleep_i(sleep_i),
    .reset_src_i(src), .limit_output_o(limit_output_o), .limit_irq_o(limit_irq_o));
  task automatic end_sim;
    if (num_errors == 0 && checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, g);
    checks++;
    if (g !== e)
    begin
      num_errors++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge clk_i);
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    wb_cyc_i <= 1;
    wb_stb_i <= 1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    wb_cyc_i <= 0;
    wb_stb_i <= 0;
    cyc(1);
  endtask
  task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] e);
    bus(0, a, 0);
    chk(nm, e, rd);
  endtask
  // Pulse to pulse, so a partial first period never counts
  task automatic gap;
    do @(posedge clk_i); while (limit_output_o !== 1'b1);
    n = 0;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (limit_output_o !== 1'b1);
  endtask
  task automatic t_regs;
    rchk("count", 8'h00, 32'h00);
    rchk("period", 8'h04, 32'hff);
    rchk("unmapped", 8'h20, 32'h00);
    bus(1, 8'h04, 32'h5a);
    rchk("period", 8'h04, 32'h5a);
    bus(1, 8'h08, 32'hfb);
    rchk("ctrl0", 8'h08, 32'h7b);
    bus(1, 8'h00, 32'h21);
    bus(1, 8'h08, 32'h00);
    rchk("count", 8'h00, 32'h21);
  endtask
  task automatic t_period;
    logic [31:0] e [4] = '{16, 64, 256, 256};
    for (int p = 0; p < 4; p++)
    begin
      bus(1, 8'h04, 32'h03);
      bus(1, 8'h00, 32'h00);
      bus(1, 8'h08, 32'h04 | p);
      gap;
      chk("gap", e[p], n);
    end
  endtask
  task automatic t_post;
    bus(1, 8'h04, 32'h01);
    bus(1, 8'h08, 32'h10);
    bus(1, 8'h10, 32'h03);
    bus(1, 8'h08, 32'h14);
    n = 0;
    while (limit_irq_o !== 1'b1)
    begin
      @(posedge clk_i);
      n += limit_output_o;
    end
    chk("post", 3, n);
    bus(1, 8'h10, 32'h01);
    repeat (3) gap;
    chk("mask", 0, limit_irq_o);
    rchk("flag", 8'h10, 32'h01);
  endtask
  task automatic t_hold;
    sleep_i <= 1;
    bus(0, 8'h00, 0);
    n = rd;
    cyc(40);
    rchk("sleep", 8'h00, n);
    sleep_i <= 0;
    bus(1, 8'h08, 32'h00);
    bus(0, 8'h00, 0);
    n = rd;
    cyc(40);
    rchk("off", 8'h00, n);
  endtask
  // Select first with edges off, so the old source cannot fake an edge
  task automatic ext(input logic [2:0] s, input logic [1:0] en, input logic f, input logic c);
    bus(1, 8'h0c, {s, 2'b00});
    which <= s;
    lvl <= !f;
    cyc(3);
    bus(1, 8'h0c, {s, en});
    bus(1, 8'h00, 32'h80);
    lvl <= f;
    n = 0;
    repeat (16)
    begin
      @(posedge clk_i);
      n += limit_output_o;
    end
    chk("ext pulse", 0, n);
    bus(0, 8'h00, 0);
    chk("ext clear", c, rd[7:0] < 8'h08);
  endtask
  task automatic t_ext;
    // Period at the longest allowed duty, so no match can fall inside the 16-cycle window
    bus(1, 8'h04, 32'hff);
    bus(1, 8'h08, 32'h04);
    for (int s = 0; s < 6; s++)
      ext(3'(s), 2'b01, 1, 1);
    ext(3'h2, 2'b10, 0, 1);
    ext(3'h2, 2'b01, 0, 0);
    ext(3'h2, 2'b10, 1, 0);
    ext(3'h6, 2'b11, 1, 0);
  endtask
  initial
  begin
    cyc(2);
    rst_i <= 0;
    t_regs;
    t_period;
    t_post;
    t_hold;
    t_ext;
    end_sim;
  end
  initial
  begin
    cyc(20000);
    num_errors++;
    end_sim;
  end
endmodule // hardware_limit_timer_tb
